// File: burst_sram_pkg.sv
// constants and types of the pipelined burst sram control block.
// assumes a single 100 MHz clock; every bus input is synchronous to it
// except output enable and the sleep request, which arrive asynchronously.
package burst_sram_pkg;

  // array geometry
  localparam int ADDR_W_DEF = 17;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int LANE_W = BYTE_W + 1;
  localparam int BURST_W = 2;

  // sleep timing, in clock cycles as specified
  localparam int SLEEP_ENTRY_TIME_CYC = 2;
  localparam int SLEEP_RECOVERY_TIME_CYC = 2;
  // the two-stage synchroniser supplies exactly these delays
  localparam int SLEEP_SYNC_STAGES = SLEEP_ENTRY_TIME_CYC;

  // byte masks
  localparam logic [LANES-1:0] MASK_ALL = 4'hf;
  localparam logic [LANES-1:0] MASK_NONE = 4'h0;

  // burst step values
  localparam logic [BURST_W-1:0] STEP_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] STEP_ONE = 2'h1;

  // access state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BURST = 2'b10
  } access_state_type;

endpackage

// File: pipelined_burst_sram_control.sv
// pipelined burst sram: cycle decode, burst counter, byte writes,
// output-enable masking and sleep control around a flip-flop array.
// assumes the bus master drives every input but output enable and the sleep request
// synchronously to clock and keeps its own sleep and write protocol.
`timescale 1ns/1ps
`default_nettype none

module pipelined_burst_sram_control #(
  parameter int ADDR_W = burst_sram_pkg::ADDR_W_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // address and burst control
  input wire logic [ADDR_W-1:0] address,
  input wire logic linearOrder,
  input wire logic burst_step_n,
  // chip selects and strobes
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  // write qualifiers
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [burst_sram_pkg::LANES-1:0] byte_select_n,
  // output enable, asynchronous
  input wire logic outputEnableN,
  // sleep request, asynchronous
  input wire logic sleep_request,
  // common data and parity pins, split in three
  input wire logic [burst_sram_pkg::DATA_W-1:0] dataIn,
  input wire logic [burst_sram_pkg::PAR_W-1:0] parity_io_in,
  output logic [burst_sram_pkg::DATA_W-1:0] dataOut,
  output logic [burst_sram_pkg::PAR_W-1:0] parity_io_out,
  output logic dataOe,
  // status
  output logic sleeping
);
  import burst_sram_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  localparam int HI_W = ADDR_W - BURST_W;

  // the burst counter replaces the low address bits
  if (ADDR_W < BURST_W + 1) begin : gen_addr_check
    $error("ADDR_W must exceed the burst counter width");
  end
  // sleep timing is carried by the synchroniser depth alone
  if (SLEEP_SYNC_STAGES != 2 || SLEEP_RECOVERY_TIME_CYC != SLEEP_ENTRY_TIME_CYC) begin : gen_zz_check
    $error("sleep timing must match the two-stage synchroniser");
  end
  // lanes must tile the data bus exactly
  if (LANES * BYTE_W != DATA_W) begin : gen_lane_check
    $error("byte lanes must cover the data bus");
  end
  // one parity bit per lane, stored beside its byte
  if (PAR_W != LANES || LANE_W != BYTE_W + 1) begin : gen_par_check
    $error("each lane needs exactly one parity bit");
  end
  // the wraparound sequences are defined for four beats only
  if (BURST_W != 2) begin : gen_burst_check
    $error("the burst counter must be two bits wide");
  end
  // the array lives in flops, so very deep arrays are refused
  if (ADDR_W > 20) begin : gen_depth_check
    $error("ADDR_W too large for a flop array");
  end

  typedef struct packed {
    logic sleepMeta;
    logic sleepSync;
    access_state_type state;
    logic [HI_W-1:0] addrHi;
    logic [BURST_W-1:0] startLow;
    logic [BURST_W-1:0] step;
    logic rdPend;
    logic [ADDR_W-1:0] rdAddr;
    logic driveEn;
    logic [DATA_W-1:0] dataOut;
    logic [PAR_W-1:0] parOut;
  } ctrl_type;

  ctrl_type s_r;
  ctrl_type s_nxt;

  // array of 36-bit words, each lane holds a data byte and its parity
  logic [LANES*LANE_W-1:0] mem [DEPTH];

  // write port, computed from the current cycle
  logic wrEn;
  logic [ADDR_W-1:0] wrAddr;
  logic [LANES-1:0] wrMask;
  logic [LANES*LANE_W-1:0] wrWord;

  // decode helpers
  logic selFirst;
  logic selSecond;
  logic selThird;
  logic csOk;
  logic procStart;
  logic startReq;
  logic sleepBlock;
  logic [ADDR_W-1:0] burstAddr;
  logic [LANES-1:0] byteMask;
  logic [BURST_W-1:0] stepNext;
  logic [BURST_W-1:0] lowNext;
  logic [BURST_W-1:0] lowCur;
  logic [LANES*LANE_W-1:0] rdWord;

  // write qualification: global write overrides the byte enables
  always_comb begin
    if (!global_write_n) begin
      // all four lanes at once
      byteMask = MASK_ALL;
    end else if (!byte_write_enable_n) begin
      // only the lanes whose select is low
      byteMask = ~byte_select_n;
    end else begin
      // nothing to write: the cycle reads
      byteMask = MASK_NONE;
    end
  end

  // each select judged on its own, in its own polarity
  assign selFirst = !chip_select_first_n;
  assign selSecond = chip_select_second;
  assign selThird = !chip_select_third_n;
  // full select pattern for a start
  assign csOk = selFirst && selSecond && selThird;
  // processor strobe only counts with the first select low
  assign procStart = !processor_addr_strobe_n && selFirst;
  // either strobe asks for a new cycle
  assign startReq = procStart || !controller_addr_strobe_n;
  // synchronised sleep blocks every access and drops a pending one
  assign sleepBlock = s_r.sleepSync;

  // burst sequence: xor for interleaved, add for linear
  assign stepNext = BURST_W'(s_r.step + STEP_ONE);
  assign lowCur = linearOrder ? BURST_W'(s_r.startLow + s_r.step)
                              : (s_r.startLow ^ s_r.step);
  assign lowNext = linearOrder ? BURST_W'(s_r.startLow + stepNext)
                               : (s_r.startLow ^ stepNext);
  // address of the current beat: repeat on step high, next on step low
  assign burstAddr = {s_r.addrHi, burst_step_n ? lowCur : lowNext};

  // merge incoming data and parity into lanes
  always_comb begin
    wrWord = '0;
    for (int i = 0; i < LANES; i++) begin
      wrWord[i*LANE_W +: LANE_W] = {parity_io_in[i], dataIn[i*BYTE_W +: BYTE_W]};
    end
  end

  assign rdWord = mem[s_r.rdAddr];

  // next-state logic for the whole control path
  always_comb begin
    s_nxt = s_r;
    wrEn = 1'b0;
    wrAddr = '0;
    wrMask = MASK_NONE;
    // sleep request passes two flops before anything reads it
    s_nxt.sleepMeta = sleep_request;
    s_nxt.sleepSync = s_r.sleepMeta;

    // output pipeline: a read sampled last edge is driven now
    s_nxt.driveEn = s_r.rdPend;
    s_nxt.rdPend = 1'b0;
    if (s_r.rdPend) begin
      // the array is read before this edge's write lands
      s_nxt.dataOut = dataOutOf(rdWord);
      s_nxt.parOut = parOutOf(rdWord);
    end

    if (sleepBlock) begin
      // sleeping: pending access is abandoned, the array is untouched
      s_nxt.state = ST_IDLE;
      s_nxt.driveEn = 1'b0;
      s_nxt.rdPend = 1'b0;
    end else if (startReq) begin
      if (!csOk) begin
        // deselect floats the outputs at this very edge
        // and ends any burst, so a later beat cannot resume it
        s_nxt.state = ST_IDLE;
        s_nxt.driveEn = 1'b0;
      end else begin
        // new access: capture address, counter loads low bits
        s_nxt.state = ST_BURST;
        s_nxt.addrHi = address[ADDR_W-1:BURST_W];
        s_nxt.startLow = address[BURST_W-1:0];
        s_nxt.step = STEP_ZERO;
        if (!procStart && byteMask != MASK_NONE) begin
          // controller-strobe write lands in this single clock
          wrEn = 1'b1;
          wrAddr = address;
          wrMask = byteMask;
          s_nxt.driveEn = 1'b0;
        end else begin
          // processor strobe always reads, write inputs ignored
          s_nxt.rdPend = 1'b1;
          s_nxt.rdAddr = address;
        end
      end
    end else begin
      // no strobe: only a running burst moves on
      unique case (s_r.state)
        ST_IDLE: begin
          // deselected or fresh from reset: stay put, pins float
          s_nxt.state = ST_IDLE;
        end
        ST_BURST: begin
          // continue on step low, suspend at the same address otherwise
          if (!burst_step_n) begin
            s_nxt.step = stepNext;
          end
          if (byteMask != MASK_NONE) begin
            // a later beat may write, whichever strobe opened the burst
            wrEn = 1'b1;
            wrAddr = burstAddr;
            wrMask = byteMask;
            s_nxt.driveEn = 1'b0;
          end else begin
            s_nxt.rdPend = 1'b1;
            s_nxt.rdAddr = burstAddr;
          end
        end
      endcase
    end
  end

  // pick the data byte of every lane
  function automatic logic [DATA_W-1:0] dataOutOf(input logic [LANES*LANE_W-1:0] w);
    logic [DATA_W-1:0] d;
    d = '0;
    for (int i = 0; i < LANES; i++) begin
      d[i*BYTE_W +: BYTE_W] = w[i*LANE_W +: BYTE_W];
    end
    return d;
  endfunction

  // pick the parity bit of every lane
  function automatic logic [PAR_W-1:0] parOutOf(input logic [LANES*LANE_W-1:0] w);
    logic [PAR_W-1:0] p;
    p = '0;
    for (int i = 0; i < LANES; i++) begin
      p[i] = w[i*LANE_W + BYTE_W];
    end
    return p;
  endfunction

  // control register; constants only under reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{
        sleepMeta: 1'b0,
        sleepSync: 1'b0,
        state: ST_IDLE,
        addrHi: '0,
        startLow: STEP_ZERO,
        step: STEP_ZERO,
        rdPend: 1'b0,
        rdAddr: '0,
        driveEn: 1'b0,
        dataOut: '0,
        parOut: '0
      };
    end else begin
      s_r <= s_nxt;
    end
  end

  // array write, byte lanes gated; no reset so contents survive
  always_ff @(posedge clock) begin
    if (wrEn) begin
      for (int i = 0; i < LANES; i++) begin
        if (wrMask[i]) begin
          mem[wrAddr][i*LANE_W +: LANE_W] <= wrWord[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // read data and parity straight from the output flops
  assign dataOut = s_r.dataOut;
  assign parity_io_out = s_r.parOut;

  // the enable alone is gated by output enable combinationally,
  // since that pin must never wait for a clock edge
  assign dataOe = s_r.driveEn && !outputEnableN;

  // status: the second synchroniser stage, two clocks behind the pin
  assign sleeping = s_r.sleepSync;

endmodule

`default_nettype wire

// File: bus_wire_model.sv
// bus master side of the shared data and parity lines.
// assumes the device drives only while dataOe is high; no pull on the lines.
`timescale 1ns/1ps
`default_nettype none
module bus_wire_model (
  // clock and master drive
  input wire logic clock,
  input wire logic outputEnableN,
  input wire logic mDrive,
  input wire logic [35:0] mData,
  // device drive and resolved lines
  input wire logic dataOe,
  input wire logic [35:0] devData,
  output logic [35:0] pins
);
  logic [35:0] last_r = 36'h0;
  // master drives only with output enable high, so it never fights the device
  always_comb begin
    if (dataOe) begin
      pins = devData;
    end else if (mDrive && outputEnableN) begin
      pins = mData;
    end else begin
      pins = ~last_r; // floating lines must not show a stale value
    end
  end
  // last resolved level, for the floating pattern
  always_ff @(posedge clock) begin
    last_r <= pins;
  end
endmodule
`default_nettype wire

// File: pipelined_burst_sram_control_asserts.sv
// port-level checker for the burst sram control block.
// assumes one clock domain and the asynchronous active-low reset nrst.
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_control_asserts (
  // clock, reset and bus controls
  input wire logic clock, nrst, burst_step_n, chip_select_first_n, chip_select_second,
  input wire logic chip_select_third_n, processor_addr_strobe_n, controller_addr_strobe_n,
  input wire logic global_write_n, byte_write_enable_n, outputEnableN, sleep_request,
  input wire logic [3:0] byte_select_n,
  // device outputs
  input wire logic [31:0] dataOut,
  input wire logic dataOe, sleeping
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic selOk;
  logic noStrobe;
  // select decode and quiet strobes
  assign selOk = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  assign noStrobe = processor_addr_strobe_n && controller_addr_strobe_n;
  // read start followed by a plain read cycle; a write next would float the pins
  sequence readStart_s;
    !processor_addr_strobe_n && selOk && !sleeping && !sleep_request ##1
      noStrobe && global_write_n && byte_write_enable_n;
  endsequence
  sequence writeStart_s;
    !controller_addr_strobe_n && processor_addr_strobe_n && selOk && !sleeping &&
      (!global_write_n || (!byte_write_enable_n && byte_select_n != 4'hf));
  endsequence
  oe_mask_a: assert property (outputEnableN |-> !dataOe)
    else $error("drive with output enable off");
  read_drive_a: assert property (readStart_s |=> dataOe == !outputEnableN)
    else $error("read not driven");
  write_float_a: assert property (writeStart_s |=> !dataOe)
    else $error("drive during write");
  deselect_float_a: assert property ((!controller_addr_strobe_n ||
      (!processor_addr_strobe_n && !chip_select_first_n)) && !selOk |=> !dataOe)
    else $error("drive after deselect");
  sleep_entry_a: assert property ($rose(sleep_request) |-> !sleeping[*2] ##1 sleeping)
    else $error("sleep entry time");
  sleep_exit_a: assert property ($fell(sleep_request) |-> sleeping[*2] ##1 !sleeping)
    else $error("sleep exit time");
  sleep_quiet_a: assert property (sleeping[*2] |-> !dataOe)
    else $error("drive while asleep");
  suspend_hold_a: assert property (dataOe && noStrobe && burst_step_n && global_write_n &&
      byte_write_enable_n && !sleeping |=> ##1 $stable(dataOut))
    else $error("suspend changed data");
endmodule
bind pipelined_burst_sram_control pipelined_burst_sram_control_asserts i_chk (
  .clock(clock), .nrst(nrst), .burst_step_n(burst_step_n),
  .chip_select_first_n(chip_select_first_n), .chip_select_second(chip_select_second),
  .chip_select_third_n(chip_select_third_n), .processor_addr_strobe_n(processor_addr_strobe_n),
  .controller_addr_strobe_n(controller_addr_strobe_n), .global_write_n(global_write_n),
  .byte_write_enable_n(byte_write_enable_n), .outputEnableN(outputEnableN),
  .sleep_request(sleep_request), .byte_select_n(byte_select_n), .dataOut(dataOut),
  .dataOe(dataOe), .sleeping(sleeping));
`default_nettype wire

// File: pipelined_burst_sram_control_tb.sv
// self-checking bench for the burst sram control block, 16-word array.
// assumes the package, the bus wire model and the checker compile first.
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_control_tb;
  logic clock = 0, nrst = 0, linearOrder = 0, stepN = 1, cs1N = 1, cs2 = 0, cs3N = 1;
  logic procN = 1, ctrlN = 1, gwN = 1, bweN = 1, oeN = 1, sleepReq = 0, mDrive = 0;
  logic dataOe, sleeping;
  logic [3:0] addr = 4'h0, bsN = 4'hf, pOut;
  logic [31:0] dOut;
  logic [35:0] mData = 36'h0, pins, mem [16];
  int miscompares = 0, checked = 0;
  always #5 clock = ~clock;
  pipelined_burst_sram_control #(.ADDR_W(4)) i_dut (.clock(clock), .nrst(nrst), .address(addr),
    .linearOrder(linearOrder), .burst_step_n(stepN), .chip_select_first_n(cs1N),
    .chip_select_second(cs2), .chip_select_third_n(cs3N), .processor_addr_strobe_n(procN),
    .controller_addr_strobe_n(ctrlN), .global_write_n(gwN), .byte_write_enable_n(bweN),
    .byte_select_n(bsN), .outputEnableN(oeN), .sleep_request(sleepReq), .dataIn(pins[31:0]),
    .parity_io_in(pins[35:32]), .dataOut(dOut), .parity_io_out(pOut), .dataOe(dataOe),
    .sleeping(sleeping));
  bus_wire_model i_bus (.clock(clock), .outputEnableN(oeN), .mDrive(mDrive), .mData(mData),
    .dataOe(dataOe), .devData({pOut, dOut}), .pins(pins));
  task automatic cmp(input string what, input logic [35:0] exp, input logic [35:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // controller-strobe write; output enable high first, expected array kept here
  task automatic wr(input logic [3:0] a, input logic [35:0] d, input logic [3:0] ln,
      input logic glob);
    @(negedge clock);
    {cs1N, cs2, cs3N, procN, ctrlN, oeN, mDrive} = 7'b0101011;
    {addr, mData, gwN, bweN} = {a, d, !glob, glob};
    bsN = glob ? 4'hf : ~ln; // global write must override idle selects
    for (int l = 0; l < 4; l++) begin
      if (glob || ln[l]) begin
        mem[a][8*l+:8] = d[8*l+:8];
        mem[a][32+l] = d[32+l];
      end
    end
  endtask
  // processor-strobe start with global write low, which must still read
  task automatic pstart(input logic [3:0] a);
    @(negedge clock);
    {cs1N, cs2, cs3N, procN, ctrlN, gwN, bweN, oeN, mDrive, stepN} = 10'b0100101001;
    addr = a;
  endtask
  task automatic rd(input logic [3:0] a);
    pstart(a);
    @(negedge clock);
    {procN, gwN} = 2'b11;
    @(negedge clock);
    cmp("read data", mem[a], {pOut, dOut});
    cmp("read drive", 36'h1, {35'h0, dataOe});
    oeN = 1;
    #1;
    cmp("oe float", 36'h0, {35'h0, dataOe});
  endtask
  // four-beat burst, then three suspended cycles on the last address
  task automatic burst(input logic [3:0] a, input logic lin);
    logic [1:0] s, j;
    pstart(a);
    linearOrder = lin;
    for (int k = 1; k < 7; k++) begin
      @(negedge clock);
      {procN, gwN, oeN, stepN} = {3'b110, k >= 4};
      j = (k > 5) ? 2'h3 : 2'(k - 2);
      s = lin ? a[1:0] + j : a[1:0] ^ j;
      if (k > 1) cmp("burst data", mem[{a[3:2], s}], {pOut, dOut});
    end
  endtask
  task automatic pwr(input logic [3:0] a, input logic [35:0] d);
    pstart(a);
    @(negedge clock);
    {procN, oeN, mDrive, mData} = {3'b111, d};
    mem[a] = d;
  endtask
  // processor strobe with select one high must not restart the burst
  task automatic ignore_proc(input logic [3:0] a);
    pstart(a);
    @(negedge clock);
    {cs1N, procN, gwN, addr} = {3'b101, a ^ 4'h1};
    @(negedge clock);
    @(negedge clock);
    cmp("ignored strobe", mem[a], {pOut, dOut});
  endtask
  task automatic nap();
    wr(4'h9, 36'h5_1234_5678, 4'h0, 1'b1);
    @(negedge clock);
    {cs1N, mDrive} = 2'b10;
    @(negedge clock);
    {ctrlN, sleepReq} = 2'b11;
    cmp("deselect float", 36'h0, {35'h0, dataOe});
    @(negedge clock);
    cmp("sleep early", 36'h0, {35'h0, sleeping});
    @(negedge clock);
    cmp("asleep", 36'h1, {35'h0, sleeping});
    {cs1N, ctrlN, mDrive, mData} = {3'b001, 36'h0};
    @(negedge clock);
    {cs1N, cs2, cs3N, ctrlN, mDrive, sleepReq} = 6'b101100;
    @(negedge clock);
    cmp("wake early", 36'h1, {35'h0, sleeping});
    @(negedge clock);
    cmp("awake", 36'h0, {35'h0, sleeping});
    rd(4'h9);
  endtask
  initial begin
    repeat (5) @(negedge clock);
    nrst = 1;
    for (int i = 0; i < 16; i++) wr(4'(i), {9{4'(i)}}, 4'h0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      burst(4'(i) + 4'h4, 1'b0);
      burst(4'(i) + 4'h8, 1'b1);
    end
    for (int l = 0; l < 16; l++) begin
      wr(4'h3, {9{4'(l)}} ^ 36'h9_a5a5_a5a5, 4'(l), 1'b0);
      rd(4'h3);
    end
    pwr(4'h6, 36'hc_0ffe_e123);
    rd(4'h6);
    ignore_proc(4'h5);
    nap();
    summarize();
  end
  // watchdog against a hung run
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
